// ===== hdl/csvt_defs.vh
// Constants for the cyclic velocity and torque command block
`ifndef CSVT_DEFS_VH
`define CSVT_DEFS_VH

// Object indexes on the object port
`define CSVT_OBJ_CTRL 16'h6040
`define CSVT_OBJ_STAT 16'h6041
`define CSVT_OBJ_MODE 16'h6060
`define CSVT_OBJ_MODE_DISP 16'h6061
`define CSVT_OBJ_POS_ACT 16'h6064
`define CSVT_OBJ_VEL_ACT 16'h606c
`define CSVT_OBJ_TRQ_SET 16'h6071
`define CSVT_OBJ_TRQ_ACT 16'h6077
`define CSVT_OBJ_ACC 16'h6083
`define CSVT_OBJ_VEL_SET 16'h60ff
`define CSVT_OBJ_LIMIT 16'h2086

// Operating mode codes
`define CSVT_MODE_CSV 8'h09
`define CSVT_MODE_CST 8'h0a

// Reset values
`define CSVT_RST_CTRL 16'h0000
`define CSVT_RST_MODE 8'h00
`define CSVT_RST_TRQ 16'h0000
`define CSVT_RST_VEL 32'h00000000
`define CSVT_RST_ACC 32'h00000000
`define CSVT_RST_LIMIT 16'h0000

// Status word bit positions
`define CSVT_ST_RDY 0
`define CSVT_ST_ON 1
`define CSVT_ST_OPEN 2
`define CSVT_ST_VOLT 4
`define CSVT_ST_QSTOP 5
`define CSVT_ST_SOD 6
`define CSVT_ST_REMOTE 9
`define CSVT_ST_RSV10 10
`define CSVT_ST_SETPT 12
`define CSVT_ST_RSV13 13

// Control word command patterns on the low four bits
`define CSVT_CW_SHUTDOWN_MASK 4'h7
`define CSVT_CW_SHUTDOWN 4'h6
`define CSVT_CW_SWITCH_ON 4'h7
`define CSVT_CW_ENABLE 4'hf

// Torque scaling numerator: internal units = 65520 * amps / (2 * peak amps)
`define CSVT_TRQ_SCALE 17'd65520

`endif

// ===== hdl/csvt_ramp.v
// Acceleration limited velocity command generator
`timescale 1ns/100ps
`default_nettype none

module csvt_ramp (
	// Clock, reset, enable
	input wire mclk_i,
	input wire rst_i,
	input wire ce_i,
	// Control
	input wire tick_i,
	input wire run_i,
	input wire limit_i,
	// Setpoints in 16.16 internal units
	input wire [31:0] target_i,
	input wire [31:0] accel_i,
	// Ramped command
	output reg [31:0] vel_o
);

	wire signed [32:0] diff;
	wire signed [32:0] acc;

	// Distance still to go and allowed step per tick
	assign diff = $signed({target_i[31], target_i}) - $signed({vel_o[31], vel_o});
	assign acc = $signed({1'b0, accel_i});

	// Step toward the target, at most one acceleration step per tick while limit_i is set; straight to it when clear
	always @(posedge mclk_i) begin
		if (rst_i) begin
			vel_o <= 32'h00000000;
		end else if (ce_i) begin
			if (!run_i) begin
				vel_o <= 32'h00000000;
			end else if (tick_i) begin
				if (!limit_i) begin
					vel_o <= target_i;
				end else if (diff > acc) begin
					vel_o <= vel_o + accel_i;
				end else if (diff < -acc) begin
					vel_o <= vel_o - accel_i;
				end else begin
					vel_o <= target_i;
				end
			end
		end
	end

endmodule
`default_nettype wire

// ===== hdl/csvt_core.v
// Cyclic velocity and torque setpoint handling with drive state machine
`include "csvt_defs.vh"
`timescale 1ns/100ps
`default_nettype none

module csvt_core (
	// Clock, reset, enable
	input wire mclk_i,
	input wire rst_i,
	input wire ce_i,
	// Object access port from the process data handler
	input wire obj_wr_i,
	input wire obj_rd_i,
	input wire [15:0] obj_idx_i,
	input wire [31:0] obj_wdata_i,
	output reg [31:0] obj_rdata_o,
	output reg obj_ack_o,
	output reg obj_err_o,
	// Drive configuration and control loop timing
	input wire spd_loop_en_i,
	input wire loop_tick_i,
	// Measured values
	input wire [31:0] act_pos_i,
	input wire [31:0] act_vel_i,
	input wire [15:0] act_trq_i,
	// Commands to the control loops
	output reg [31:0] vel_cmd_o,
	output reg vel_loop_on_o,
	output reg [15:0] trq_cmd_o,
	output reg trq_cmd_new_o,
	output reg trq_loop_on_o,
	output reg motion_start_o,
	// Drive state
	output reg [15:0] status_o,
	output reg [7:0] mode_disp_o
);

	// Drive states
	localparam [1:0] ST_SOD = 2'b00;
	localparam [1:0] ST_READY = 2'b01;
	localparam [1:0] ST_ON = 2'b10;
	localparam [1:0] ST_OPEN = 2'b11;

	// Objects held by the block
	reg [15:0] ctrl_word;
	reg [7:0] mode;
	reg [15:0] torque_setpoint;
	reg [15:0] torque_readback;
	reg [31:0] vel_setpoint;
	reg [31:0] prof_accel;
	reg [15:0] limit_ctl;
	reg [31:0] pos_act;
	reg [31:0] vel_act;
	reg [1:0] drv_state;
	reg [1:0] next_drv_state;
	reg [15:0] next_status;
	reg vel_new;
	reg trq_new;
	wire csv_run;
	wire cst_run;
	wire [31:0] ramp_vel;

	// Object index decode for reads; writes are checked against writable_obj
	function known_obj;
		input [15:0] idx;
		begin
			case (idx)
				`CSVT_OBJ_CTRL, `CSVT_OBJ_STAT, `CSVT_OBJ_MODE,
				`CSVT_OBJ_MODE_DISP, `CSVT_OBJ_POS_ACT, `CSVT_OBJ_VEL_ACT,
				`CSVT_OBJ_TRQ_SET, `CSVT_OBJ_TRQ_ACT, `CSVT_OBJ_ACC,
				`CSVT_OBJ_VEL_SET, `CSVT_OBJ_LIMIT: known_obj = 1'b1;
				default: known_obj = 1'b0;
			endcase
		end
	endfunction

	// Objects that accept writes
	function writable_obj;
		input [15:0] idx;
		begin
			case (idx)
				`CSVT_OBJ_CTRL, `CSVT_OBJ_MODE, `CSVT_OBJ_TRQ_SET,
				`CSVT_OBJ_ACC, `CSVT_OBJ_VEL_SET,
				`CSVT_OBJ_LIMIT: writable_obj = 1'b1;
				default: writable_obj = 1'b0;
			endcase
		end
	endfunction

	// Write enable shared by all writable objects
	wire wr_ok;
	assign wr_ok = obj_wr_i && writable_obj(obj_idx_i);

	// Setpoint objects written from process data
	always @(posedge mclk_i) begin
		if (rst_i) begin
			ctrl_word <= `CSVT_RST_CTRL;
			mode <= `CSVT_RST_MODE;
			torque_setpoint <= `CSVT_RST_TRQ;
			vel_setpoint <= `CSVT_RST_VEL;
			prof_accel <= `CSVT_RST_ACC;
			limit_ctl <= `CSVT_RST_LIMIT;
			vel_new <= 1'b0;
			trq_new <= 1'b0;
		end else if (ce_i) begin
			vel_new <= 1'b0;
			trq_new <= 1'b0;
			// Strobes last one cycle; a write on the clearing edge still
			// sets them because its assignment comes last
			if (wr_ok) begin
				case (obj_idx_i)
					`CSVT_OBJ_CTRL: ctrl_word <= obj_wdata_i[15:0];
					`CSVT_OBJ_MODE: mode <= obj_wdata_i[7:0];
					`CSVT_OBJ_TRQ_SET: begin
						torque_setpoint <= obj_wdata_i[15:0];
						trq_new <= 1'b1;
					end
					`CSVT_OBJ_VEL_SET: begin
						vel_setpoint <= obj_wdata_i;
						vel_new <= 1'b1;
					end
					`CSVT_OBJ_ACC: prof_accel <= obj_wdata_i;
					`CSVT_OBJ_LIMIT: limit_ctl <= obj_wdata_i[15:0];
					default: ctrl_word <= ctrl_word;
				endcase
			end
		end
	end

	// Generic drive state machine, only the generic control bits steer it
	always @* begin
		next_drv_state = drv_state;
		case (drv_state)
			ST_SOD: begin
				if ((ctrl_word[3:0] & `CSVT_CW_SHUTDOWN_MASK) == `CSVT_CW_SHUTDOWN)
					next_drv_state = ST_READY;
			end
			ST_READY: begin
				if (!ctrl_word[1])
					next_drv_state = ST_SOD;
				else if (ctrl_word[3:0] == `CSVT_CW_SWITCH_ON)
					next_drv_state = ST_ON;
				// Enable from ready passes through switched on first, so the
				// loops never start without a switched-on cycle
				else if (ctrl_word[3:0] == `CSVT_CW_ENABLE)
					next_drv_state = ST_ON;
			end
			ST_ON: begin
				if (!ctrl_word[1])
					next_drv_state = ST_SOD;
				else if (ctrl_word[3:0] == `CSVT_CW_ENABLE)
					next_drv_state = ST_OPEN;
				else if (ctrl_word[3:0] == `CSVT_CW_SHUTDOWN)
					next_drv_state = ST_READY;
			end
			ST_OPEN: begin
				if (!ctrl_word[1])
					next_drv_state = ST_SOD;
				else if (ctrl_word[3:0] == `CSVT_CW_SWITCH_ON)
					next_drv_state = ST_ON;
				else if (ctrl_word[3:0] == `CSVT_CW_SHUTDOWN)
					next_drv_state = ST_READY;
			end
			default: next_drv_state = ST_SOD;
		endcase
	end

	// Drive state register and displayed mode
	always @(posedge mclk_i) begin
		if (rst_i) begin
			drv_state <= ST_SOD;
			mode_disp_o <= `CSVT_RST_MODE;
		end else if (ce_i) begin
			drv_state <= next_drv_state;
			mode_disp_o <= mode;
		end
	end

	// Which mode is actually driving the loops
	assign csv_run = (drv_state == ST_OPEN) && (mode == `CSVT_MODE_CSV) &&
		spd_loop_en_i;
	assign cst_run = (drv_state == ST_OPEN) && (mode == `CSVT_MODE_CST);

	// Velocity ramp toward the 16.16 target
	// With the limit off the ramp follows the target on each tick;
	// a zero acceleration with the limit on holds the command still
	csvt_ramp u_ramp (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.tick_i(loop_tick_i),
		.run_i(csv_run),
		.limit_i(limit_ctl[0]),
		.target_i(vel_setpoint),
		.accel_i(prof_accel),
		.vel_o(ramp_vel)
	);

	// Status word: generic state bits plus the mode specific bit 12
	always @* begin
		next_status = 16'h0000;
		next_status[`CSVT_ST_RDY] = (drv_state != ST_SOD);
		next_status[`CSVT_ST_ON] = (drv_state == ST_ON) || (drv_state == ST_OPEN);
		next_status[`CSVT_ST_OPEN] = (drv_state == ST_OPEN);
		next_status[`CSVT_ST_VOLT] = (drv_state != ST_SOD);
		next_status[`CSVT_ST_QSTOP] = 1'b1;
		next_status[`CSVT_ST_SOD] = (drv_state == ST_SOD);
		next_status[`CSVT_ST_REMOTE] = 1'b1;
		// Reserved in both cyclic modes, so always read as zero
		next_status[`CSVT_ST_RSV10] = 1'b0;
		next_status[`CSVT_ST_RSV13] = 1'b0;
		next_status[`CSVT_ST_SETPT] = csv_run || cst_run;
	end

	// Loop commands and the reported actual values
	always @(posedge mclk_i) begin
		if (rst_i) begin
			vel_cmd_o <= 32'h00000000;
			vel_loop_on_o <= 1'b0;
			trq_cmd_o <= `CSVT_RST_TRQ;
			trq_cmd_new_o <= 1'b0;
			trq_loop_on_o <= 1'b0;
			motion_start_o <= 1'b0;
			status_o <= 16'h0000;
			pos_act <= 32'h00000000;
			vel_act <= 32'h00000000;
			torque_readback <= 16'h0000;
		end else if (ce_i) begin
			status_o <= next_status;
			// Velocity mode closes speed and torque loops internally
			vel_loop_on_o <= csv_run;
			vel_cmd_o <= ramp_vel;
			motion_start_o <= csv_run && vel_new;
			// Torque mode runs the torque loop alone
			trq_loop_on_o <= csv_run || cst_run;
			trq_cmd_new_o <= cst_run && trq_new;
			// Forced to zero outside torque mode so a stale setpoint is
			// never applied when the mode is entered again
			if (!cst_run)
				trq_cmd_o <= `CSVT_RST_TRQ;
			else if (trq_new)
				trq_cmd_o <= torque_setpoint;
			// Actual values sampled once per control cycle
			if (loop_tick_i) begin
				pos_act <= act_pos_i;
				vel_act <= act_vel_i;
				torque_readback <= act_trq_i;
			end
		end
	end

	// Object reads and the answer to every access
	always @(posedge mclk_i) begin
		if (rst_i) begin
			obj_rdata_o <= 32'h00000000;
			obj_ack_o <= 1'b0;
			obj_err_o <= 1'b0;
		end else if (ce_i) begin
			obj_ack_o <= obj_wr_i || obj_rd_i;
			obj_err_o <= (obj_wr_i && !writable_obj(obj_idx_i)) ||
				(obj_rd_i && !known_obj(obj_idx_i));
			obj_rdata_o <= 32'h00000000;
			// A read in the same cycle as a write returns the old value,
			// since the object register only updates on this edge
			if (obj_rd_i) begin
				case (obj_idx_i)
					`CSVT_OBJ_CTRL: obj_rdata_o <= {16'h0000, ctrl_word};
					`CSVT_OBJ_STAT: obj_rdata_o <= {16'h0000, status_o};
					`CSVT_OBJ_MODE: obj_rdata_o <= {24'h000000, mode};
					`CSVT_OBJ_MODE_DISP: obj_rdata_o <= {24'h000000, mode_disp_o};
					`CSVT_OBJ_POS_ACT: obj_rdata_o <= pos_act;
					`CSVT_OBJ_VEL_ACT: obj_rdata_o <= vel_act;
					`CSVT_OBJ_TRQ_SET: obj_rdata_o <= {{16{torque_setpoint[15]}},
						torque_setpoint};
					`CSVT_OBJ_TRQ_ACT: obj_rdata_o <= {{16{torque_readback[15]}},
						torque_readback};
					`CSVT_OBJ_ACC: obj_rdata_o <= prof_accel;
					`CSVT_OBJ_VEL_SET: obj_rdata_o <= vel_setpoint;
					`CSVT_OBJ_LIMIT: obj_rdata_o <= {16'h0000, limit_ctl};
					default: obj_rdata_o <= 32'h00000000;
				endcase
			end
		end
	end

endmodule
`default_nettype wire

// ===== test/csvt_ctl.sv
// Motion controller model driving the object port
`timescale 1ns/100ps
`default_nettype none
module csvt_ctl (
	// Clock
	input wire logic mclk_i,
	// Object requests
	output logic obj_wr_o,
	output logic obj_rd_o,
	output logic [15:0] obj_idx_o,
	output logic [31:0] obj_wdata_o,
	// Object answers
	input wire logic [31:0] obj_rdata_i,
	input wire logic obj_ack_i,
	input wire logic obj_err_i
);
	logic [31:0] rd_q;
	logic err_q;
	logic to_q;
	// Idle port at time zero
	initial begin
		obj_wr_o = 1'b0;
		obj_rd_o = 1'b0;
		obj_idx_o = 16'h0000;
		obj_wdata_o = 32'h00000000;
	end
	// One access: strobe for one take edge, then bounded wait for ack
	task automatic acc(input logic w, input logic [15:0] i, input logic [31:0] d);
		int n;
		@(posedge mclk_i);
		#1;
		obj_wr_o = w;
		obj_rd_o = !w;
		obj_idx_o = i;
		obj_wdata_o = d;
		@(posedge mclk_i);
		#1;
		obj_wr_o = 1'b0;
		obj_rd_o = 1'b0;
		obj_idx_o = ~i; // Released lines do not keep the last value
		obj_wdata_o = ~d;
		n = 0;
		while (obj_ack_i !== 1'b1 && n < 8) begin
			@(posedge mclk_i);
			#1;
			n++;
		end
		rd_q = obj_rdata_i;
		err_q = obj_err_i;
		to_q = (n == 8);
	endtask
	// Drive state steps: shutdown, switch on, then enable
	task automatic power_up();
		acc(1'b1, 16'h6040, 32'h00000006);
		acc(1'b1, 16'h6040, 32'h00000007);
		acc(1'b1, 16'h6040, 32'h0000000f);
	endtask
endmodule
`default_nettype wire

// ===== test/csvt_chk.sv
// Port assertions for the cyclic velocity and torque block
`include "csvt_defs.vh"
`timescale 1ns/100ps
`default_nettype none
module csvt_chk (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// Inputs
	input wire logic ce_i,
	input wire logic obj_wr_i,
	input wire logic obj_rd_i,
	input wire logic [15:0] obj_idx_i,
	input wire logic spd_loop_en_i,
	// Outputs
	input wire logic [31:0] obj_rdata_o,
	input wire logic obj_ack_o,
	input wire logic obj_err_o,
	input wire logic vel_loop_on_o,
	input wire logic trq_cmd_new_o,
	input wire logic trq_loop_on_o,
	input wire logic motion_start_o,
	input wire logic [15:0] status_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	wire req = ce_i && (obj_wr_i || obj_rd_i);
	// Access answers and their causes
	ack_follows_a: assert property (req |=> obj_ack_o) else $error("ack missing");
	ack_cause_a: assert property (obj_ack_o |-> $past(req) || !$past(ce_i))
		else $error("stray ack");
	rdata_idle_a: assert property (!obj_ack_o |-> obj_rdata_o == 32'h0) else $error("rdata");
	err_ack_a: assert property (obj_err_o |-> obj_ack_o) else $error("err without ack");
	ro_write_a: assert property (ce_i && obj_wr_i && obj_idx_i == `CSVT_OBJ_TRQ_ACT
		|=> obj_err_o) else $error("write to torque readback");
	known_rd_a: assert property (ce_i && obj_rd_i && obj_idx_i == `CSVT_OBJ_TRQ_SET
		&& !obj_wr_i |=> !obj_err_o) else $error("known read errored");
	// Status word and loop relations
	rsv_bits_a: assert property (!status_o[10] && !status_o[13]) else $error("reserved");
	setpt_op_a: assert property (status_o[12] |-> status_o[2]) else $error("bit12");
	spd_need_a: assert property ($rose(vel_loop_on_o) |-> $past(spd_loop_en_i))
		else $error("spd");
	start_vel_a: assert property (motion_start_o |-> vel_loop_on_o) else $error("start");
	trq_new_a: assert property (trq_cmd_new_o |-> trq_loop_on_o) else $error("trq new");
	c_start: cover property (motion_start_o);
	c_trq: cover property (trq_cmd_new_o);
	c_err: cover property (obj_err_o);
endmodule
bind csvt_core csvt_chk csvt_chk_inst (.mclk_i, .rst_i, .ce_i, .obj_wr_i, .obj_rd_i,
	.obj_idx_i, .spd_loop_en_i, .obj_rdata_o, .obj_ack_o, .obj_err_o, .vel_loop_on_o,
	.trq_cmd_new_o, .trq_loop_on_o, .motion_start_o, .status_o);
`default_nettype wire

// ===== test/tb_top.sv
// Self-checking bench for the cyclic velocity and torque block
`include "csvt_defs.vh"
`timescale 1ns/100ps
`default_nettype none
`define CMP(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; \
	$display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	logic ce = 1'b1;
	logic spd = 1'b0;
	logic tick = 1'b0;
	logic [31:0] apos = 32'h12345678;
	logic [31:0] avel = 32'h00028000;
	logic [15:0] atrq = 16'hfffe;
	wire wr, rd, ack, err, von, tnew, ton, mst;
	wire [15:0] idx, tcmd, st;
	wire [31:0] wd, rdat, vcmd;
	wire [7:0] md;
	int n_errors = 0;
	int n_checks = 0;
	int tc = 0;
	int ms_n = 0;
	int tn_n = 0;
	int k;
	// Clock, control tick every fourth cycle, pulse counters
	always #4 mclk_i = ~mclk_i;
	always @(negedge mclk_i) begin
		ms_n += mst;
		tn_n += tnew;
	end
	always @(posedge mclk_i) begin
		tc++;
		#1 tick = (tc % 4 == 0);
	end
	csvt_ctl csvt_ctl_inst (.mclk_i(mclk_i), .obj_wr_o(wr), .obj_rd_o(rd), .obj_idx_o(idx),
		.obj_wdata_o(wd), .obj_rdata_i(rdat), .obj_ack_i(ack), .obj_err_i(err));
	csvt_core csvt_core_inst (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce), .obj_wr_i(wr),
		.obj_rd_i(rd), .obj_idx_i(idx), .obj_wdata_i(wd), .obj_rdata_o(rdat), .obj_ack_o(ack),
		.obj_err_o(err), .spd_loop_en_i(spd), .loop_tick_i(tick), .act_pos_i(apos),
		.act_vel_i(avel), .act_trq_i(atrq), .vel_cmd_o(vcmd), .vel_loop_on_o(von),
		.trq_cmd_o(tcmd), .trq_cmd_new_o(tnew), .trq_loop_on_o(ton), .motion_start_o(mst),
		.status_o(st), .mode_disp_o(md));
	// Verdict and end of run
	task automatic complete_run();
		$display("checks=%0d mismatches=%0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// One access with expected read data and error flag
	task automatic op(input logic w, input logic [15:0] i, input logic [31:0] d,
		input logic [31:0] e, input logic ee);
		csvt_ctl_inst.acc(w, i, d);
		if (csvt_ctl_inst.to_q) begin
			n_errors++;
			complete_run();
		end else begin
			if (!w) `CMP(csvt_ctl_inst.rd_q, e)
			`CMP(csvt_ctl_inst.err_q, ee)
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask
	initial begin
		repeat (8) @(posedge mclk_i);
		#1 rst_i = 1'b0;
		idle(1);
		`CMP(st, 16'h0260)
		op(0, `CSVT_OBJ_TRQ_SET, 0, 32'h0, 0);
		op(0, 16'h1234, 0, 32'h0, 1);
		$display("test reset done");
		csvt_ctl_inst.power_up();
		idle(3);
		`CMP(st & 16'h3407, 16'h0007)
		op(1, `CSVT_OBJ_MODE, `CSVT_MODE_CSV, 0, 0);
		idle(3);
		`CMP(md, `CSVT_MODE_CSV)
		`CMP({st[12], von}, 2'b00)
		spd = 1'b1;
		idle(3);
		`CMP({st[12], von}, 2'b11)
		op(1, `CSVT_OBJ_CTRL, 32'h0000007f, 0, 0);
		idle(3);
		`CMP(st & 16'h3407, 16'h1007)
		$display("test states done");
		op(1, `CSVT_OBJ_LIMIT, 32'h1, 0, 0);
		op(1, `CSVT_OBJ_ACC, 32'h00010000, 0, 0);
		k = ms_n;
		op(1, `CSVT_OBJ_VEL_SET, 32'h00030000, 0, 0);
		idle(2);
		`CMP(ms_n - k, 1)
		for (k = 0; k < 16 && vcmd === 32'h0; k++) idle(1);
		`CMP(vcmd, 32'h00010000)
		ce = 1'b0;
		idle(12);
		`CMP(vcmd, 32'h00010000)
		ce = 1'b1;
		idle(24);
		`CMP(vcmd, 32'h00030000)
		op(0, `CSVT_OBJ_POS_ACT, 0, apos, 0);
		op(0, `CSVT_OBJ_VEL_ACT, 0, avel, 0);
		$display("test velocity done");
		op(1, `CSVT_OBJ_MODE, `CSVT_MODE_CST, 0, 0);
		idle(3);
		`CMP({md, st[12]}, {`CSVT_MODE_CST, 1'b1})
		k = tn_n;
		op(1, `CSVT_OBJ_TRQ_SET, 32'h00008001, 0, 0);
		idle(2);
		`CMP(tcmd, 16'h8001)
		`CMP(tn_n - k, 1)
		`CMP(vcmd, 32'h0)
		op(0, `CSVT_OBJ_TRQ_SET, 0, 32'hffff8001, 0);
		op(0, `CSVT_OBJ_TRQ_ACT, 0, 32'hfffffffe, 0);
		op(1, `CSVT_OBJ_TRQ_ACT, 32'h1, 0, 1);
		op(0, `CSVT_OBJ_TRQ_ACT, 0, 32'hfffffffe, 0);
		op(1, `CSVT_OBJ_TRQ_SET, `CSVT_TRQ_SCALE / 4, 0, 0);
		idle(2);
		`CMP(tcmd, 16'h3ffc)
		$display("test torque done");
		rst_i = 1'b1;
		idle(2);
		rst_i = 1'b0;
		idle(1);
		`CMP({st, tcmd, von, ton}, {16'h0260, 16'h0000, 2'b00})
		op(0, `CSVT_OBJ_TRQ_SET, 0, 32'h0, 0);
		$display("test reset again done");
		complete_run();
	end
endmodule
`default_nettype wire
